// *** logic/lcell_pkg.sv ***
package lcell_pkg;
	// Register byte offsets on the APB window
	localparam logic [7:0] OFF_CTRL_LO = 8'h00;
	localparam logic [7:0] OFF_CTRL_HI = 8'h04;
	localparam logic [7:0] OFF_SEL = 8'h08;
	localparam logic [7:0] OFF_GATE_LO = 8'h0C;
	localparam logic [7:0] OFF_GATE_HI = 8'h10;
	localparam logic [7:0] OFF_IRQ_ST = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	// Implemented-bit masks, everything else reads zero except the output status bit in cell_control_low
	localparam logic [15:0] MASK_CTRL_LO = 16'h8CA7;
	localparam logic [15:0] MASK_CTRL_HI = 16'h000F;
	localparam logic [15:0] MASK_SEL = 16'h7777;
	localparam logic [15:0] MASK_GATE = 16'hFFFF;
	localparam logic [15:0] MASK_IRQ = 16'h0003;
	localparam logic [15:0] RST_REG = 16'h0000;
	// Field positions in cell_control_low
	localparam int POS_ON = 15;
	localparam int POS_RISE_EN = 11;
	localparam int POS_FALL_EN = 10;
	localparam int POS_OE = 7;
	localparam int POS_OUT_ST = 6;
	localparam int POS_OUT_INV = 5;
	localparam int MODE_W = 3;
	// Selector fields are 3 bits on a 4-bit pitch
	localparam int SEL_W = 3;
	localparam int SEL_PITCH = 4;
	localparam int NUM_SRC = 8;
	localparam int NUM_GATE = 4;
	// Status and mask bit positions
	localparam int IRQ_RISE = 0;
	localparam int IRQ_FALL = 1;
	// Candidate codes that are overridden inside the cell
	localparam logic [2:0] CODE_EXT = 3'h0;
	localparam logic [2:0] CODE_DMA = 3'h5;

	typedef enum logic [2:0] {
		LCELL_AND_OR = 3'b000,
		LCELL_OR_XOR = 3'b001,
		LCELL_AND4 = 3'b010,
		LCELL_SR = 3'b011,
		LCELL_DFF1 = 3'b100,
		LCELL_DFF2 = 3'b101,
		LCELL_JK = 3'b110,
		LCELL_LATCH = 3'b111
	} lcell_mode_t;

	// Eight candidates per selector, index equals code
	typedef struct packed {
		logic [7:0] sel4;
		logic [7:0] sel3;
		logic [7:0] sel2;
		logic [7:0] sel1;
	} lcell_cand_t;

	typedef struct packed {
		logic o;
		logic oe;
	} lcell_pin_t;
endpackage : lcell_pkg

// *** logic/lcell_core.sv ***
// Function
// R1: Software controls enable, irq edges, oe, polarity, mode
// R2: Output and gate polarity are software invertible
// R3: Four 3-bit selector fields in select register
// R4: Each selector picks one of eight candidates
// R5: Selectors give true and complement signals
// R6: Each gate ORs its enabled selector signals
// R7: Pin driven only while pin drive enabled
// R8: Codes 0-2 are AND-OR, OR-XOR, AND4
// R9: Code 3 SR latch, 7 transparent latch
// R10: Code 4 D flop S/R, 5 two-input D
// R11: Code 6 JK flop with reset
// R12: Gate invert bits flip gate outputs
// R13: Unimplemented bits ignore writes, read zero
// R14: Cells 1-2 selector two code 5 DMA0
// R15: Cells 3-4 selector three code 5 DMA1
// R16: Status bit and edge irqs follow final output
// R17: Disabled cell outputs low, resets, no irqs
//
// Our own choices: register access over APB and the placing of the registers.
module lcell_core
	import lcell_pkg::*;
#(
	parameter int CELL_NUM = 1
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire lcell_cand_t cand,
	input wire logic ext_input_a,
	input wire logic ext_input_b,
	input wire logic dma0_irq,
	input wire logic dma1_irq,
	output lcell_pin_t pin,
	output logic cell_out,
	output logic irq
);
	logic [15:0] ctrl_lo_r;
	logic [15:0] ctrl_hi_r;
	logic [15:0] sel_r;
	logic [15:0] gate_lo_r;
	logic [15:0] gate_hi_r;
	logic [15:0] irq_st_r;
	logic [15:0] irq_mask_r;
	logic [31:0] prdata_r;
	logic [2:0] ext_a_r;
	logic [2:0] ext_b_r;
	logic ext_a_q_r;
	logic ext_b_q_r;
	logic [3:0] src_d;
	logic [3:0] gate_q;
	logic [NUM_SRC-1:0] gate_en [NUM_GATE];
	logic fn_comb;
	logic q_r;
	logic g1_prev_r;
	logic g1_rise;
	logic cell_out_r;
	logic out_prev_r;
	logic cell_nxt;
	logic setup;
	logic wr;
	logic mapped;
	logic [15:0] rd_nxt;
	logic [15:0] irq_set;
	logic cell_on;
	lcell_mode_t mode;

	// Field picks from a packed selector register
	function automatic logic [2:0] sel_field(input logic [15:0] r, input int i);
		sel_field = r[i*SEL_PITCH +: SEL_W];
	endfunction : sel_field

	// OR of enabled true/negated sources for one gate
	function automatic logic gate_or(input logic [7:0] en, input logic [3:0] d);
		logic acc;
		acc = 1'b0;
		for (int s = 0; s < NUM_GATE; s++) begin
			acc = acc | (en[2*s+1] & d[s]) | (en[2*s] & ~d[s]);
		end
		gate_or = acc;
	endfunction : gate_or

	assign cell_on = ctrl_lo_r[POS_ON];
	assign mode = lcell_mode_t'(ctrl_lo_r[MODE_W-1:0]);
	assign setup = psel & ~penable;
	assign wr = psel & penable & pwrite;

	// APB decode; zero wait states
	always_comb begin
		mapped = 1'b1;
		case (paddr)
			OFF_CTRL_LO: rd_nxt = ctrl_lo_r | (16'(cell_out_r) << POS_OUT_ST); // see R16
			OFF_CTRL_HI: rd_nxt = ctrl_hi_r;
			OFF_SEL: rd_nxt = sel_r;
			OFF_GATE_LO: rd_nxt = gate_lo_r;
			OFF_GATE_HI: rd_nxt = gate_hi_r;
			OFF_IRQ_ST: rd_nxt = irq_st_r;
			OFF_IRQ_MASK: rd_nxt = irq_mask_r;
			default: begin
				rd_nxt = 16'h0000;
				mapped = 1'b0;
			end
		endcase
	end

	assign pready = 1'b1;
	assign pslverr = psel & penable & ~mapped;
	assign prdata = prdata_r;

	// Read data latched in the setup cycle so it comes from flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup) begin
			prdata_r <= {16'h0000, rd_nxt}; // see R13
		end
	end

	// Control registers; masks drop writes to unimplemented bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_lo_r <= RST_REG;
			ctrl_hi_r <= RST_REG;
			sel_r <= RST_REG;
			gate_lo_r <= RST_REG;
			gate_hi_r <= RST_REG;
			irq_mask_r <= RST_REG;
		end else begin
			if (wr && paddr == OFF_CTRL_LO) begin
				ctrl_lo_r <= pwdata[15:0] & MASK_CTRL_LO; // see R1
			end
			if (wr && paddr == OFF_CTRL_HI) begin
				ctrl_hi_r <= pwdata[15:0] & MASK_CTRL_HI; // see R13
			end
			if (wr && paddr == OFF_SEL) begin
				sel_r <= pwdata[15:0] & MASK_SEL; // see R3
			end
			if (wr && paddr == OFF_GATE_LO) begin
				gate_lo_r <= pwdata[15:0] & MASK_GATE;
			end
			if (wr && paddr == OFF_GATE_HI) begin
				gate_hi_r <= pwdata[15:0] & MASK_GATE;
			end
			if (wr && paddr == OFF_IRQ_MASK) begin
				irq_mask_r <= pwdata[15:0] & MASK_IRQ;
			end
		end
	end

	// Pin inputs: three stages, accept once stages two and three agree
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_a_r <= 3'h0;
			ext_b_r <= 3'h0;
			ext_a_q_r <= 1'b0;
			ext_b_q_r <= 1'b0;
		end else begin
			ext_a_r <= {ext_a_r[1:0], ext_input_a};
			ext_b_r <= {ext_b_r[1:0], ext_input_b};
			if (ext_a_r[1] == ext_a_r[2]) begin
				ext_a_q_r <= ext_a_r[2];
			end
			if (ext_b_r[1] == ext_b_r[2]) begin
				ext_b_q_r <= ext_b_r[2];
			end
		end
	end

	// Source selectors; pin and DMA slots are patched per cell
	always_comb begin
		lcell_cand_t c;
		c = cand;
		c.sel1[CODE_EXT] = ext_a_q_r;
		c.sel2[CODE_EXT] = ext_b_q_r;
		c.sel3[CODE_EXT] = ext_a_q_r;
		c.sel4[CODE_EXT] = ext_b_q_r;
		if (CELL_NUM <= 2) begin
			c.sel2[CODE_DMA] = dma0_irq; // see R14
		end else begin
			c.sel3[CODE_DMA] = dma1_irq; // see R15
		end
		src_d[0] = c.sel1[sel_field(sel_r, 0)]; // see R4
		src_d[1] = c.sel2[sel_field(sel_r, 1)];
		src_d[2] = c.sel3[sel_field(sel_r, 2)];
		src_d[3] = c.sel4[sel_field(sel_r, 3)];
	end

	assign gate_en[0] = gate_lo_r[7:0];
	assign gate_en[1] = gate_lo_r[15:8];
	assign gate_en[2] = gate_hi_r[7:0];
	assign gate_en[3] = gate_hi_r[15:8];

	// Gates OR true/negated sources, then optional invert
	for (genvar g = 0; g < NUM_GATE; g++) begin : g_gate
		assign gate_q[g] = gate_or(gate_en[g], src_d) ^ ctrl_hi_r[g]; // see R5 see R6 see R12
	end

	// Combinational functions; sequential modes read the state bit
	always_comb begin
		case (mode)
			LCELL_AND_OR: fn_comb = (gate_q[0] & gate_q[1]) | (gate_q[2] & gate_q[3]); // see R8
			LCELL_OR_XOR: fn_comb = (gate_q[0] | gate_q[1]) ^ (gate_q[2] | gate_q[3]);
			LCELL_AND4: fn_comb = &gate_q;
			default: fn_comb = q_r;
		endcase
	end

	assign g1_rise = gate_q[0] & ~g1_prev_r;

	// Gate one is the clock of the flop modes, sampled on pclk
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			g1_prev_r <= 1'b0;
		end else begin
			g1_prev_r <= gate_q[0];
		end
	end

	// Storage element; reset has priority over set, except in SR mode where set wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			q_r <= 1'b0;
		end else if (!cell_on) begin
			q_r <= 1'b0; // see R17
		end else begin
			case (mode)
				LCELL_SR: begin
					if (gate_q[0] | gate_q[1]) begin
						q_r <= 1'b1; // see R9
					end else if (gate_q[2] | gate_q[3]) begin
						q_r <= 1'b0;
					end
				end
				LCELL_DFF1: begin
					if (gate_q[2]) begin
						q_r <= 1'b0; // see R10
					end else if (gate_q[3]) begin
						q_r <= 1'b1;
					end else if (g1_rise) begin
						q_r <= gate_q[1];
					end
				end
				LCELL_DFF2: begin
					if (gate_q[2]) begin
						q_r <= 1'b0;
					end else if (g1_rise) begin
						q_r <= gate_q[1] ^ gate_q[3]; // see R10
					end
				end
				LCELL_JK: begin
					if (gate_q[2]) begin
						q_r <= 1'b0; // see R11
					end else if (g1_rise) begin
						case ({gate_q[1], gate_q[3]})
							2'b10: q_r <= 1'b1;
							2'b01: q_r <= 1'b0;
							2'b11: q_r <= ~q_r;
							default: q_r <= q_r;
						endcase
					end
				end
				LCELL_LATCH: begin
					if (gate_q[2]) begin
						q_r <= 1'b0; // see R9
					end else if (gate_q[3]) begin
						q_r <= 1'b1;
					end else if (gate_q[0]) begin
						q_r <= gate_q[1];
					end
				end
				default: q_r <= 1'b0;
			endcase
		end
	end

	// Final output register: polarity, then forced low when off
	assign cell_nxt = cell_on & (fn_comb ^ ctrl_lo_r[POS_OUT_INV]); // see R2 see R17

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cell_out_r <= 1'b0;
			out_prev_r <= 1'b0;
		end else begin
			cell_out_r <= cell_nxt;
			out_prev_r <= cell_out_r;
		end
	end

	// Status bit mirrors the output; kept outside the write mask
	assign cell_out = cell_out_r;
	assign pin.o = cell_out_r;
	assign pin.oe = ctrl_lo_r[POS_OE]; // see R7

	// Edge events on the polarity-corrected output
	always_comb begin
		irq_set = 16'h0000;
		irq_set[IRQ_RISE] = cell_on & ctrl_lo_r[POS_RISE_EN] & cell_out_r & ~out_prev_r; // see R16
		irq_set[IRQ_FALL] = cell_on & ctrl_lo_r[POS_FALL_EN] & ~cell_out_r & out_prev_r;
	end

	// Sticky status, write one clears, a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_st_r <= RST_REG;
		end else if (wr && paddr == OFF_IRQ_ST) begin
			irq_st_r <= ((irq_st_r & ~pwdata[15:0]) | irq_set) & MASK_IRQ;
		end else begin
			irq_st_r <= irq_st_r | irq_set;
		end
	end

	assign irq = |(irq_st_r & irq_mask_r);

	AST_OFF_LOW: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		!cell_on |=> !cell_out_r)
		else $error("output not low while cell disabled");

	AST_OE_WRITE: assert property (@(posedge pclk) disable iff (!presetn) // see R7
		(wr && paddr == OFF_CTRL_LO) |=> (pin.oe == $past(pwdata[POS_OE])))
		else $error("pin enable does not follow write");

	AST_AND4: assert property (@(posedge pclk) disable iff (!presetn) // see R8
		(cell_on && mode == LCELL_AND4) |=> cell_out_r == (&$past(gate_q) ^ $past(ctrl_lo_r[POS_OUT_INV])))
		else $error("four-input AND result wrong");

	AST_RISE_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // see R16
		(cell_on && ctrl_lo_r[POS_RISE_EN] && cell_out_r && !out_prev_r) |=> irq_st_r[IRQ_RISE])
		else $error("rising edge did not set status");

	AST_NO_IRQ_OFF: assert property (@(posedge pclk) disable iff (!presetn) // see R17
		!cell_on |=> (irq_st_r & ~$past(irq_st_r)) == 16'h0000)
		else $error("interrupt raised while disabled");

	AST_RO_ZERO: assert property (@(posedge pclk) disable iff (!presetn) // see R13
		(setup && paddr == OFF_CTRL_HI) |=> prdata[31:4] == 28'h000_0000)
		else $error("unimplemented bits read non-zero");

	AST_DMA_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // see R14
		(CELL_NUM <= 2 && sel_field(sel_r, 1) == CODE_DMA) |-> src_d[1] == dma0_irq)
		else $error("DMA0 not routed to selector two");

	AST_DFF2: assert property (@(posedge pclk) disable iff (!presetn) // see R10
		(cell_on && mode == LCELL_DFF2 && g1_rise && !gate_q[2]) |=> q_r == $past(gate_q[1] ^ gate_q[3]))
		else $error("two-input D flop captured wrong value");

	AST_SR_SET: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		(cell_on && mode == LCELL_SR && (gate_q[0] || gate_q[1])) |=> q_r)
		else $error("SR latch did not set");

	AST_DMA1_ROUTE: assert property (@(posedge pclk) disable iff (!presetn) // see R15
		(CELL_NUM > 2 && sel_field(sel_r, 2) == CODE_DMA) |-> src_d[2] == dma1_irq)
		else $error("DMA1 not routed to selector three");

	AST_STATUS_BIT: assert property (@(posedge pclk) disable iff (!presetn) // see R16
		(setup && paddr == OFF_CTRL_LO) |=> prdata[POS_OUT_ST] == $past(cell_out_r))
		else $error("output status bit does not follow output");

	AST_FALL_IRQ: assert property (@(posedge pclk) disable iff (!presetn) // see R16
		(cell_on && ctrl_lo_r[POS_FALL_EN] && !cell_out_r && out_prev_r) |=> irq_st_r[IRQ_FALL])
		else $error("falling edge did not set status");

	AST_JK_TOGGLE: assert property (@(posedge pclk) disable iff (!presetn) // see R11
		(cell_on && mode == LCELL_JK && g1_rise && !gate_q[2] && gate_q[1] && gate_q[3])
		|=> q_r != $past(q_r))
		else $error("JK flop did not toggle");

	AST_LATCH_OPEN: assert property (@(posedge pclk) disable iff (!presetn) // see R9
		(cell_on && mode == LCELL_LATCH && gate_q[0] && !gate_q[2] && !gate_q[3])
		|=> q_r == $past(gate_q[1]))
		else $error("open latch did not pass data");
endmodule : lcell_core

// *** tb/lcell_src_model.sv ***
// Stands in for the peripherals and pins that feed the cell
module lcell_src_model
	import lcell_pkg::*;
(
	input wire logic pclk,
	input wire logic [35:0] want,
	output lcell_cand_t cand,
	output logic ext_a,
	output logic ext_b,
	output logic dma0,
	output logic dma1
);
	timeunit 1ns;
	timeprecision 1ps;
	// Sources move only on the clock, like same-domain peripherals
	always @(posedge pclk) begin
		{dma1, dma0, ext_b, ext_a, cand} <= want;
	end
endmodule : lcell_src_model

// *** tb/configurable_logic_cell_tb.sv ***
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; \
	$display("unexpected %s: expected %h, seen %h", nm, e, g); end end
module configurable_logic_cell_tb import lcell_pkg::*; ();
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready, cell_out, irq, last_err, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdq;
	logic [35:0] want;
	logic ext_a, ext_b, dma0, dma1;
	lcell_cand_t cand;
	lcell_pin_t pin;
	int errors, tests_run;
	// Free-running 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	lcell_core #(.CELL_NUM(1)) DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cand(cand), .ext_input_a(ext_a),
		.ext_input_b(ext_b), .dma0_irq(dma0), .dma1_irq(dma1), .pin(pin),
		.cell_out(cell_out), .irq(irq));
	lcell_src_model src (.pclk(pclk), .want(want), .cand(cand), .ext_a(ext_a),
		.ext_b(ext_b), .dma0(dma0), .dma1(dma1));
	task automatic summarize();
		$display("tests_run %0d errors %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : summarize
	// One APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
			if (n > 20) begin
				errors++;
				summarize();
			end
		end while (pready !== 1'b1);
		rdq = prdata;
		last_err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] x, input string nm);
		apb(1'b0, a, 32'h0000_0000);
		`CHK(nm, x, rdq)
	endtask : rd
	// Reference for the three combinational functions
	function automatic logic fn(input int m, input logic [3:0] g);
		case (m)
			0: return (g[0] & g[1]) | (g[2] & g[3]);
			1: return (g[0] | g[1]) ^ (g[2] | g[3]);
			default: return &g;
		endcase
	endfunction : fn
	// Main sequence
	initial begin
		logic [3:0] g;
		logic [15:0] msk [7];
		logic [4:0] dseq [7];
		logic [36:0] xseq [4];
		logic [7:0] sq [24];
		// Inverted idle latch drives the output high, so the status bit reads one
		msk = '{MASK_CTRL_LO | (16'h0001 << POS_OUT_ST), MASK_CTRL_HI, MASK_SEL, MASK_GATE,
			MASK_GATE, 16'h0000, MASK_IRQ};
		sq = '{8'h68, 8'h63, 8'h61, 8'h70, 8'h75, 8'hA8, 8'hA4, 8'hA7, 8'hB1, 8'hB6, 8'hC8, 8'hC7,
			8'hD1, 8'hD6, 8'hD4, 8'hD7, 8'hD1, 8'hD2, 8'hE8, 8'hE7, 8'hE2, 8'hE4, 8'hF1, 8'hF8};
		dseq = '{5'h04, 5'h07, 5'h03, 5'h01, 5'h02, 5'h11, 5'h18};
		xseq = '{{36'h0_0000_0001, 1'b0}, {36'h1_0000_0000, 1'b1},
			{36'h0_0000_2000, 1'b0}, {36'h4_0000_0000, 1'b1}};
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		want = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		for (int i = 0; i < 7; i++) rd(8'(i * 4), 32'h0000_0000, "reset value");
		// Control written last so a live cell cannot disturb status first
		for (int i = 6; i >= 0; i--) begin
			wr(8'(i * 4), 32'hFFFF_FFFF);
			rd(8'(i * 4), {16'h0000, msk[i]}, "implemented bits");
		end
		for (int i = 0; i < 7; i++) wr(8'(i * 4), 32'h0000_0000);
		wr(OFF_IRQ_ST, 32'h0000_0003);
		wr(8'h1C, 32'h0000_FFFF);
		`CHK("pslverr", 1'b1, last_err)
		rd(8'h1C, 32'h0000_0000, "unmapped");
		$display("test registers done");
		// Gate n takes true source n; every field at code 1
		wr(OFF_SEL, 32'h0000_1111);
		wr(OFF_GATE_LO, 32'h0000_0802);
		wr(OFF_GATE_HI, 32'h0000_8020);
		for (int m = 0; m < 3; m++) begin
			for (int p = 0; p < 2; p++) begin
				wr(OFF_CTRL_HI, p ? 32'h0000_0005 : 32'h0000_0000);
				wr(OFF_CTRL_LO, 32'h0000_8080 | 32'(m) | (32'(p) << POS_OUT_INV));
				for (int v = 0; v < 16; v++) begin
					g = 4'(v);
					want <= {10'h000, g[3], 7'h00, g[2], 7'h00, g[1], 7'h00, g[0], 1'b0};
					repeat (4) @(posedge pclk);
					e = fn(m, g ^ (p ? 4'h5 : 4'h0)) ^ p[0];
					`CHK("cell_out", e, cell_out)
					`CHK("pin.o", e, pin.o)
					`CHK("pin.oe", 1'b1, pin.oe)
				end
			end
		end
		rd(OFF_IRQ_ST, 32'h0000_0000, "status no edge enable");
		$display("test functions done");
		// Edge events, mask and write-one-to-clear
		want <= '0;
		wr(OFF_CTRL_HI, 32'h0000_0000);
		wr(OFF_CTRL_LO, 32'h0000_8882);
		wr(OFF_IRQ_MASK, 32'h0000_0003);
		want <= 36'h0_0202_0202;
		repeat (4) @(posedge pclk);
		`CHK("irq", 1'b1, irq)
		want <= '0;
		repeat (4) @(posedge pclk);
		rd(OFF_IRQ_ST, 32'h0000_0001, "status rise only");
		wr(OFF_IRQ_MASK, 32'h0000_0000);
		@(posedge pclk);
		`CHK("irq masked", 1'b0, irq)
		wr(OFF_IRQ_MASK, 32'h0000_0003);
		wr(OFF_IRQ_ST, 32'h0000_0001);
		@(posedge pclk);
		`CHK("irq cleared", 1'b0, irq)
		wr(OFF_CTRL_LO, 32'h0000_8482);
		want <= 36'h0_0202_0202;
		repeat (4) @(posedge pclk);
		want <= '0;
		repeat (4) @(posedge pclk);
		rd(OFF_IRQ_ST, 32'h0000_0002, "status fall only");
		wr(OFF_IRQ_ST, 32'h0000_0003);
		// Pin released, then cell switched off while high
		wr(OFF_CTRL_LO, 32'h0000_8002);
		want <= 36'h0_0202_0202;
		repeat (4) @(posedge pclk);
		`CHK("pin.oe off", 1'b0, pin.oe)
		wr(OFF_CTRL_LO, 32'h0000_0C82);
		repeat (4) @(posedge pclk);
		`CHK("cell_out off", 1'b0, cell_out)
		rd(OFF_IRQ_ST, 32'h0000_0000, "status off");
		$display("test irq done");
		// Clocked D flop: clock g1, data g2, reset g3 beats set g4
		wr(OFF_CTRL_LO, 32'h0000_8004);
		for (int i = 0; i < 7; i++) begin
			g = dseq[i][4:1];
			want <= {10'h000, g[3], 7'h00, g[2], 7'h00, g[1], 7'h00, g[0], 1'b0};
			repeat (4) @(posedge pclk);
			`CHK("dff", dseq[i][0], cell_out)
		end
		// Latch and flop modes: {mode, gates four to one, expected output}
		for (int i = 0; i < 24; i++) begin
			g = sq[i][4:1];
			wr(OFF_CTRL_LO, 32'h0000_8000 | 32'(sq[i][7:5]));
			want <= {10'h000, g[3], 7'h00, g[2], 7'h00, g[1], 7'h00, g[0], 1'b0};
			repeat (4) @(posedge pclk);
			`CHK("seq mode", sq[i][0], cell_out)
		end
		$display("test modes done");
		// Slot 0 and DMA slot come from pins and DMA, not candidates
		wr(OFF_CTRL_LO, 32'h0000_8001);
		wr(OFF_SEL, 32'h0000_0050);
		wr(OFF_GATE_HI, 32'h0000_0000);
		for (int i = 0; i < 4; i++) begin
			want <= xseq[i][36:1];
			repeat (8) @(posedge pclk);
			`CHK("override", xseq[i][0], cell_out)
		end
		$display("test sources done");
		summarize();
	end
endmodule : configurable_logic_cell_tb
